/* hdl/kbd_code_modify.sv */
// Shift, alpha lock and control modification of the scan code
`timescale 1ns/100ps
`default_nettype none
module kbd_code_modify (
  kbd_code_if.mod code_io
);
  import kbd_scan_pkg::*;

  logic invert_b6;
  logic invert_b5;
  logic force_ctl;

  // ****************************************
  // Modifier terms
  // ****************************************
  assign invert_b6 = (code_io.shift & code_io.scan_code[6])
                   | (code_io.alpha_lock & code_io.scan_code[7] & code_io.scan_code[6]);
  assign invert_b5 = code_io.shift & code_io.scan_code[7] & ~code_io.scan_code[6];
  assign force_ctl = code_io.control & code_io.scan_code[6];

  assign code_io.key_code = {code_io.scan_code[6] & ~force_ctl,
                             (code_io.scan_code[5] ^ invert_b6) & ~force_ctl,
                             code_io.scan_code[4] ^ invert_b5,
                             code_io.scan_code[3:0]};
endmodule
`default_nettype wire

/* hdl/kbd_scan_counters.sv */
// Row and column scan counters with column decoder
`timescale 1ns/100ps
`default_nettype none
module kbd_scan_counters (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        advance,
  kbd_code_if.cnt          code_io,
  output logic [15:0]      col_drive_n
);
  import kbd_scan_pkg::*;

  logic [3:0]  row_reg;
  logic [3:0]  row_next;
  logic [3:0]  col_reg;
  logic [3:0]  col_next;
  logic [15:0] col_drive_next;

  // ****************************************
  // Counters
  // ****************************************
  always_comb begin
    row_next = advance ? 4'(row_reg + 4'h1) : row_reg;
    col_next = (advance && row_reg == 4'hf) ? 4'(col_reg + 4'h1) : col_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_reg <= 4'h0;
      col_reg <= 4'h0;
    end else begin
      row_reg <= row_next;
      col_reg <= col_next;
    end
  end

  assign code_io.scan_code = {col_reg, row_reg};

  // ****************************************
  // One-of-16 column decoder
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_col
      assign col_drive_next[i] = (col_next != 4'(i));
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_drive_n <= 16'hfffe;
    end else begin
      col_drive_n <= col_drive_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_col_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot(~col_drive_n) && !col_drive_n[col_reg])
    else $error("column drive is not the decoded column count");

  chk_col_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (advance && row_reg == 4'hf) |=> (row_reg == 4'h0) && (col_reg == 4'($past(col_reg) + 4'h1)))
    else $error("column did not step on row wrap");

  chk_col_still: assert property (@(posedge pclk) disable iff (!presetn)
    (row_reg != 4'hf || !advance) |=> $stable(col_reg))
    else $error("column moved without row wrap");
endmodule
`default_nettype wire

/* hdl/keyboard_matrix_scanner.sv */
// Keyboard matrix scanner top with APB registers
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "kbd_scan_cfg.svh"
module keyboard_matrix_scanner #(
  parameter int unsigned STROBE_CYCLES = `KBD_STROBE_CYC
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [11:0]             paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [15:0]             row_in,
  output logic [15:0]                  col_drive_n,
  input  wire logic                    shift_key_n,
  input  wire logic                    alpha_key_n,
  input  wire logic                    control_key_n,
  output kbd_scan_pkg::key_code_t      key_code,
  output logic                         key_strobe
);
  import kbd_scan_pkg::*;

  kbd_code_if code_io ();

  logic [15:0]  row_meta_reg;
  logic [15:0]  row_sync_reg;
  logic [2:0]   key_meta_reg;
  logic [2:0]   key_sync_reg;
  logic         alpha_prev_reg;
  logic         alpha_lock_reg;
  logic [6:0]   div_reg;
  logic         tick;
  logic         closure;
  logic         advance;
  logic         scan_en_reg;
  scan_state_e  state_reg;
  logic [21:0]  strobe_cnt_reg;
  key_code_t    key_code_reg;
  logic         strobe_reg;
  logic         pready_reg;
  logic         pslverr_reg;
  logic [31:0]  prdata_reg;
  logic         access;
  logic         wr_fire;
  logic         mapped;
  logic [31:0]  rd_value;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_meta_reg <= 16'hffff;
      row_sync_reg <= 16'hffff;
      key_meta_reg <= 3'h7;
      key_sync_reg <= 3'h7;
    end else begin
      row_meta_reg <= row_in;
      row_sync_reg <= row_meta_reg;
      key_meta_reg <= {control_key_n, alpha_key_n, shift_key_n};
      key_sync_reg <= key_meta_reg;
    end
  end

  // ****************************************
  // Alpha lock toggle
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alpha_prev_reg <= 1'b1;
      alpha_lock_reg <= 1'b0;
    end else begin
      alpha_prev_reg <= key_sync_reg[1];
      if (alpha_prev_reg && !key_sync_reg[1]) begin
        alpha_lock_reg <= !alpha_lock_reg;
      end
    end
  end

  assign code_io.shift      = !key_sync_reg[0];
  assign code_io.alpha_lock = alpha_lock_reg;
  assign code_io.control    = !key_sync_reg[2];

  // ****************************************
  // Scan clock and halt
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 7'h00;
    end else if (div_reg == 7'(`KBD_SCAN_DIV - 1)) begin
      div_reg <= 7'h00;
    end else begin
      div_reg <= 7'(div_reg + 7'h01);
    end
  end

  assign tick    = (div_reg == 7'(`KBD_SCAN_DIV - 1));
  assign closure = !row_sync_reg[code_io.scan_code[3:0]];
  assign advance = tick && scan_en_reg && !closure;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SCAN_RUN;
    end else if (tick) begin
      state_reg <= closure ? SCAN_HALT : SCAN_RUN;
    end
  end

  kbd_scan_counters u_counters (
    .pclk        (pclk),
    .presetn     (presetn),
    .advance     (advance),
    .code_io     (code_io.cnt),
    .col_drive_n (col_drive_n)
  );

  kbd_code_modify u_modify (
    .code_io (code_io.mod)
  );

  // ****************************************
  // Key code and strobe
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_code_reg <= 7'h00;
    end else begin
      key_code_reg <= code_io.key_code;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_cnt_reg <= 22'h000000;
      strobe_reg     <= 1'b0;
    end else if (advance) begin
      strobe_cnt_reg <= 22'h000000;
      strobe_reg     <= 1'b0;
    end else if (strobe_cnt_reg == 22'(STROBE_CYCLES - 1)) begin
      strobe_reg     <= 1'b1;
    end else begin
      strobe_cnt_reg <= 22'(strobe_cnt_reg + 22'h000001);
    end
  end

  assign key_code   = key_code_reg;
  assign key_strobe = strobe_reg;

  // ****************************************
  // APB slave
  // ****************************************
  assign access  = psel && penable && !pready_reg;
  assign wr_fire = psel && penable && pready_reg && pwrite;

  always_comb begin
    mapped   = 1'b1;
    rd_value = 32'h00000000;
    if (paddr == `KBD_CTRL_OFS) begin
      rd_value[`KBD_CTRL_SCAN_EN] = scan_en_reg;
    end else if (paddr == `KBD_STAT_OFS) begin
      rd_value[`KBD_STAT_HALT]    = (state_reg == SCAN_HALT);
      rd_value[`KBD_STAT_STROBE]  = strobe_reg;
      rd_value[`KBD_STAT_ALPHA]   = alpha_lock_reg;
      rd_value[`KBD_STAT_SHIFT]   = code_io.shift;
      rd_value[`KBD_STAT_CONTROL] = code_io.control;
    end else if (paddr == `KBD_CODE_OFS) begin
      rd_value[6:0] = key_code_reg;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= access;
      pslverr_reg <= access && !mapped;
      prdata_reg  <= (access && !pwrite) ? rd_value : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_en_reg <= `KBD_CTRL_RST;
    end else if (wr_fire && paddr == `KBD_CTRL_OFS) begin
      scan_en_reg <= pwdata[`KBD_CTRL_SCAN_EN];
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ****************************************
  // Checks
  // ****************************************
  chk_row_advance: assert property (@(posedge pclk) disable iff (!presetn)
    advance |=> code_io.scan_code[3:0] == 4'($past(code_io.scan_code[3:0]) + 4'h1))
    else $error("row count did not step on scan clock");

  chk_halt_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (closure && scan_en_reg) [*2] |=> $stable(code_io.scan_code))
    else $error("counters moved while a key is closed");

  chk_resume_scan: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && scan_en_reg && !closure) |=> (state_reg == SCAN_RUN) && !$stable(code_io.scan_code[3:0]))
    else $error("scan did not resume after release");

  chk_code_low: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> key_code_reg[3:0] == $past(code_io.scan_code[3:0]))
    else $error("low code bits not passed through");

  chk_bit6_shift: assert property (@(posedge pclk) disable iff (!presetn)
    (code_io.shift && !code_io.control && code_io.scan_code[6])
    |=> key_code_reg[5] == !$past(code_io.scan_code[5]))
    else $error("shift did not invert bit 6");

  chk_bit6_plain: assert property (@(posedge pclk) disable iff (!presetn)
    (!code_io.shift && !code_io.alpha_lock && !code_io.control)
    |=> key_code_reg[6:4] == $past(code_io.scan_code[6:4]))
    else $error("unmodified code bits changed");

  chk_bit5_swap: assert property (@(posedge pclk) disable iff (!presetn)
    (code_io.shift && code_io.scan_code[7] && !code_io.scan_code[6])
    |=> key_code_reg[4] == !$past(code_io.scan_code[4]))
    else $error("shift did not invert bit 5");

  chk_ctrl_force: assert property (@(posedge pclk) disable iff (!presetn)
    (code_io.control && code_io.scan_code[6]) |=> key_code_reg[6:5] == 2'b00)
    else $error("control did not clear bits 6 and 7");

  chk_strobe_clear: assert property (@(posedge pclk) disable iff (!presetn)
    advance |=> !strobe_reg && strobe_cnt_reg == 22'h000000)
    else $error("strobe not restarted by scan clock");

  chk_halt_enter: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && closure)
    |=> (state_reg == SCAN_HALT) && $stable(code_io.scan_code))
    else $error("scan clock not blocked by a closed key");

  chk_scan_off: assert property (@(posedge pclk) disable iff (!presetn)
    !scan_en_reg
    |=> $stable(code_io.scan_code))
    else $error("counters moved with scanning disabled");

  chk_alpha_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (alpha_prev_reg && !key_sync_reg[1])
    |=> alpha_lock_reg != $past(alpha_lock_reg))
    else $error("alpha lock did not toggle on press");

  chk_alpha_invert: assert property (@(posedge pclk) disable iff (!presetn)
    (code_io.alpha_lock && !code_io.control && code_io.scan_code[7] && code_io.scan_code[6])
    |=> key_code_reg[5] == !$past(code_io.scan_code[5]))
    else $error("alpha lock did not invert bit 6");

  chk_alpha_only: assert property (@(posedge pclk) disable iff (!presetn)
    (code_io.alpha_lock && !code_io.shift && !code_io.control
     && !(code_io.scan_code[7] && code_io.scan_code[6]))
    |=> key_code_reg[5] == $past(code_io.scan_code[5]))
    else $error("alpha lock changed a non-alphabetic code");

  chk_bit7_open: assert property (@(posedge pclk) disable iff (!presetn)
    !code_io.control
    |=> key_code_reg[6] == $past(code_io.scan_code[6]))
    else $error("bit 7 changed with control open");

  chk_bit5_plain: assert property (@(posedge pclk) disable iff (!presetn)
    !code_io.shift
    |=> key_code_reg[4] == $past(code_io.scan_code[4]))
    else $error("bit 5 changed with shift open");

  chk_strobe_set: assert property (@(posedge pclk) disable iff (!presetn)
    (!advance && strobe_cnt_reg == 22'(STROBE_CYCLES - 1))
    |=> strobe_reg)
    else $error("strobe did not rise after timeout");

  chk_strobe_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (strobe_reg && !advance)
    |=> strobe_reg)
    else $error("strobe dropped while halted");
endmodule
`default_nettype wire

/* pkg/kbd_code_if.sv */
// Scan code and modifier signals between scanner parts
`timescale 1ns/100ps
`default_nettype none
interface kbd_code_if;
  import kbd_scan_pkg::*;
  scan_code_t scan_code;
  logic       shift;
  logic       alpha_lock;
  logic       control;
  key_code_t  key_code;
  modport cnt (output scan_code);
  modport mod (input scan_code, input shift, input alpha_lock, input control, output key_code);
  modport ctl (input scan_code, input key_code, output shift, output alpha_lock, output control);
endinterface
`default_nettype wire

/* pkg/kbd_scan_cfg.svh */
// Constants for the keyboard matrix scanner
`ifndef KBD_SCAN_CFG_SVH
`define KBD_SCAN_CFG_SVH

// ****************************************
// Timing
// ****************************************
`define KBD_CLK_NS        8
`define KBD_SCAN_NS       1000
`define KBD_SCAN_DIV      (`KBD_SCAN_NS / `KBD_CLK_NS)
`define KBD_STROBE_MS     30
`define KBD_STROBE_CYC    (`KBD_STROBE_MS * 1000000 / `KBD_CLK_NS)

// ****************************************
// Register offsets
// ****************************************
`define KBD_CTRL_OFS      12'h000
`define KBD_STAT_OFS      12'h004
`define KBD_CODE_OFS      12'h008

// ****************************************
// Fields and reset values
// ****************************************
`define KBD_CTRL_RST      1'b1
`define KBD_CTRL_SCAN_EN  0
`define KBD_STAT_HALT     0
`define KBD_STAT_STROBE   1
`define KBD_STAT_ALPHA    2
`define KBD_STAT_SHIFT    3
`define KBD_STAT_CONTROL  4

`endif

/* pkg/kbd_scan_pkg.sv */
// Types shared by the keyboard matrix scanner
package kbd_scan_pkg;
  typedef logic [7:0] scan_code_t;
  typedef logic [6:0] key_code_t;
  typedef enum logic {SCAN_RUN, SCAN_HALT} scan_state_e;
endpackage

/* test/kbd_matrix_model.sv */
// Key switch matrix model driving the row lines
`timescale 1ns/100ps
`default_nettype none
module kbd_matrix_model (
  input  wire logic [15:0] col_drive_n,
  input  wire logic        key_down,
  input  wire logic [3:0]  key_col,
  input  wire logic [3:0]  key_row,
  output logic      [15:0] row_in
);
  // ****************************************
  // Matrix with pulled-up rows
  // ****************************************
  always_comb begin
    row_in = 16'hffff;
    if (key_down && !col_drive_n[key_col]) begin
      row_in[key_row] = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* test/tb_keyboard_matrix_scanner.sv */
// Testbench for the keyboard matrix scanner
`timescale 1ns/100ps
`default_nettype none
`include "kbd_scan_cfg.svh"
module tb_keyboard_matrix_scanner;
  import kbd_scan_pkg::*;
  localparam int unsigned STB = 200;
  logic        pclk          = 1'b0;
  logic        presetn       = 1'b0;
  logic [11:0] paddr         = 12'h000;
  logic        psel          = 1'b0;
  logic        penable       = 1'b0;
  logic        pwrite        = 1'b0;
  logic [31:0] pwdata        = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] row_in;
  logic [15:0] col_drive_n;
  logic        shift_key_n   = 1'b1;
  logic        alpha_key_n   = 1'b1;
  logic        control_key_n = 1'b1;
  key_code_t   key_code;
  logic        key_strobe;
  logic        key_down      = 1'b0;
  logic [3:0]  key_col       = 4'h0;
  logic [3:0]  key_row       = 4'h0;
  logic        alpha_on      = 1'b0;
  logic [31:0] rd;
  logic        err;
  int          errors        = 0;
  int          compares      = 0;

  always #4 pclk = ~pclk;

  keyboard_matrix_scanner #(.STROBE_CYCLES(STB)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .row_in(row_in), .col_drive_n(col_drive_n), .shift_key_n(shift_key_n),
    .alpha_key_n(alpha_key_n), .control_key_n(control_key_n), .key_code(key_code),
    .key_strobe(key_strobe)
  );

  kbd_matrix_model matrix_u (
    .col_drive_n(col_drive_n), .key_down(key_down), .key_col(key_col),
    .key_row(key_row), .row_in(row_in)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic end_of_test();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_halt(input logic v, input int lim);
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h004, 32'h0);
      n++;
    end while (rd[0] !== v && n < lim);
    if (rd[0] !== v) begin
      errors++;
      end_of_test();
    end
  endtask

  task automatic set_mods(input logic sh, input logic al, input logic ct);
    if (al !== alpha_on) begin
      alpha_key_n <= 1'b0;
      repeat (5) @(posedge pclk);
      alpha_key_n <= 1'b1;
      alpha_on = al;
    end
    shift_key_n <= ~sh;
    control_key_n <= ~ct;
    repeat (6) @(posedge pclk);
  endtask

  function automatic key_code_t exp_code(input logic [3:0] c, input logic [3:0] r,
                                         input logic sh, input logic al, input logic ct);
    logic [7:0] s;
    logic       b5;
    logic       b6;
    logic       b7;
    s = {c, r};
    b6 = s[5] ^ ((sh & s[6]) | (al & s[7] & s[6]));
    b5 = s[4] ^ (sh & s[7] & ~s[6]);
    b7 = s[6];
    if (ct & s[6]) begin
      b6 = 1'b0;
      b7 = 1'b0;
    end
    return {b7, b6, b5, s[3:0]};
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    check(32'(col_drive_n), 32'h0000fffe);
    check(32'(key_code), 32'h0);
    check(32'(key_strobe), 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, 12'h004, 32'hffffffff);
    apb(1'b0, 12'h004, 32'h0);
    check(rd & 32'h1d, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
  endtask

  task automatic t_scan();
    int n;
    n = 0;
    while (col_drive_n !== 16'hfffd && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (col_drive_n !== 16'hfffd) begin
      errors++;
      end_of_test();
    end
    n = 0;
    while (col_drive_n !== 16'hfffb && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (col_drive_n !== 16'hfffb) begin
      errors++;
      end_of_test();
    end
    check(32'(n), 32'(16 * `KBD_SCAN_DIV));
  endtask

  task automatic t_freeze();
    logic [15:0] cd;
    key_code_t   kc;
    apb(1'b1, `KBD_CTRL_OFS, 32'h0);
    apb(1'b0, `KBD_CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    cd = col_drive_n;
    kc = key_code;
    repeat (STB + 2 * `KBD_SCAN_DIV) @(posedge pclk);
    check(32'(col_drive_n), {16'h0, cd});
    check(32'(key_code), 32'(kc));
    check(32'(key_strobe), 32'h1);
    apb(1'b1, `KBD_CTRL_OFS, 32'h1);
    apb(1'b0, `KBD_CTRL_OFS, 32'h0);
    check(rd, 32'h1);
  endtask

  task automatic t_key(input logic [3:0] c, input logic [3:0] r);
    key_code_t e;
    key_col <= c;
    key_row <= r;
    key_down <= 1'b1;
    wait_halt(1'b1, 12000);
    check(32'(rd[0]), 32'h1);
    check(32'(key_strobe), 32'h0);
    check(32'(col_drive_n), {16'h0, ~(16'h1 << c)});
    for (int i = 0; i < 8; i++) begin
      set_mods(i[0], i[2], i[1]);
      e = exp_code(c, r, i[0], i[2], i[1]);
      check(32'(key_code), 32'(e));
      apb(1'b0, 12'h004, 32'h0);
      check(32'(rd[4:0] & 5'h1d), {27'h0, i[1], i[0], i[2], 2'b01});
    end
    set_mods(1'b0, 1'b0, 1'b0);
    repeat (STB) @(posedge pclk);
    check(32'(key_strobe), 32'h1);
    check(32'(col_drive_n), {16'h0, ~(16'h1 << c)});
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'(exp_code(c, r, 1'b0, 1'b0, 1'b0)));
    key_down <= 1'b0;
    wait_halt(1'b0, 60);
    check(32'(rd[0]), 32'h0);
    repeat (2) @(posedge pclk);
    check(32'(key_strobe), 32'h0);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_scan();
    t_freeze();
    t_key(4'h3, 4'h2);
    t_key(4'h6, 4'h5);
    t_key(4'ha, 4'h9);
    t_key(4'hf, 4'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
